/* File: hw/ssxc_top.sv */
// Purpose: Sub-CPU serial register port and transfer control register
// Assumes: Link pins are slow against sys_clk (bit clock near 5 MHz)
// Notes: Open-collector data line, only ever pulled low
// What this block does
// RL1 - Burst bit picks single or multi word
// RL2 - Method bit picks DMA or programmed I/O
// RL3 - Enable bit gates sub-CPU transfer interrupt
// RL4 - Three-bit route field selects transfer path
// RL5 - Host to sub-CPU: PIO, twelve bytes
// RL6 - Legacy modes allow only four routes; not enforced, atapi_mode only picks the limit for routes 0 and 1
// RL7 - Link uses sync, open-collector data, clock
// RL8 - Sync pulse, then eight-bit address byte
// RL9 - Address bit 7 set means ignore
// RL10 - Pointer advances after every byte
// RL11 - Mode zero increments, wraps, sticks at zero
// RL12 - Mode one reads follow read chain
// RL13 - Mode one writes follow write chain
// RL14 - Address field loads the pointer
// RL15 - Address bit 0 gives direction
// RL16 - Reset clears control, drive number one
// RL17 - Selected only when drive bits match
// RL18 - MSB first, sample rise, change fall
// RL19 - Reserved control bit reads zero
`timescale 1ns/10ps
`default_nettype none
module ssxc_top
    import ssxc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic frame_sync,
    input wire logic bit_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Host side status
    input wire logic atapi_mode,
    input wire logic host_drive_select,
    input wire logic sub_xfer_event,
    // Transfer control outputs
    output logic burst_style_sel,
    output logic dma_not_pio,
    output logic sub_irq_en,
    output logic own_drive_number,
    output logic [2:0] transfer_route,
    output logic route_reserved,
    output logic route_pio_only,
    output logic [15:0] route_max_bytes,
    output logic dma_active,
    output logic drive_selected,
    output logic sub_transfer_irq
);
    import ssxc_pkg::*;

    // Pin synchronisers and filtered levels
    logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_f_d;
    logic [2:0] pin_f_old_q;
    // Link state
    ssxc_state_type state_q, state_d;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [4:0] ptr_q;
    logic mode_q;
    logic [7:0] xc_q;
    logic [7:0] tx_byte_q;
    logic tx_load_q;
    logic is_interface_status_q;

    // RL7 three link wires
    assign pin_f_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));

    // Three stages; a change counts when stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_s1_q <= 3'h7;
            pin_s2_q <= 3'h7;
            pin_s3_q <= 3'h7;
            pin_f_q <= 3'h7;
            pin_f_old_q <= 3'h7;
        end else begin
            pin_s1_q <= {frame_sync, bit_clk, sda_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q <= pin_f_d;
            pin_f_old_q <= pin_f_q;
        end
    end

    // Edge events on filtered levels
    wire sync_rise = pin_f_q[2] & ~pin_f_old_q[2];
    wire clk_rise = pin_f_q[1] & ~pin_f_old_q[1];
    wire clk_fall = ~pin_f_q[1] & pin_f_old_q[1];
    wire data_bit = pin_f_q[0];
    wire [7:0] rx_byte = {shift_q[6:0], data_bit};
    wire byte_done = clk_rise && (bit_cnt_q == SSXC_LAST_BIT);

    // RL11 mode zero step
    wire ptr_wraps = (ptr_q == SSXC_PTR_WRAP_LO) || (ptr_q == SSXC_PTR_WRAP_HI);
    wire [4:0] next_lin = (ptr_q == SSXC_PTR_PORT || ptr_wraps) ? SSXC_PTR_PORT :
                          5'(ptr_q + 5'h01);
    // RL12 read chain step
    wire rd_run1 = (ptr_q >= SSXC_RD_RUN1_FIRST) && (ptr_q < SSXC_RD_RUN1_LAST);
    wire rd_run2 = (ptr_q >= SSXC_RD_RUN2_FIRST) && (ptr_q < SSXC_RD_RUN2_LAST);
    wire [4:0] next_rd = (rd_run1 || rd_run2) ? 5'(ptr_q + 5'h01) : SSXC_PTR_PORT;
    // RL13 write chain step
    wire wr_run1 = (ptr_q >= SSXC_WR_RUN1_FIRST) && (ptr_q < SSXC_WR_RUN1_LAST);
    wire wr_run2 = (ptr_q >= SSXC_WR_RUN2_FIRST) && (ptr_q < SSXC_WR_RUN2_LAST);
    wire [4:0] next_wr = (ptr_q == SSXC_WR_RUN1_LAST) ? SSXC_WR_RUN2_FIRST :
                         (wr_run1 || wr_run2) ? 5'(ptr_q + 5'h01) : SSXC_PTR_PORT;
    // RL10 policy chosen by address mode
    wire [4:0] next_ptr = !mode_q ? next_lin :
                          (state_q == SSXC_RDATA) ? next_rd : next_wr;

    // Address byte decode
    wire ab_done = byte_done && (state_q == SSXC_ADDR);
    wire ab_for_us = ~rx_byte[SSXC_AB_SELECT];
    wire ab_read = rx_byte[SSXC_AB_DIR];
    wire [4:0] ab_reg = rx_byte[SSXC_AB_REG_HI:SSXC_AB_REG_LO];

    // Write of a received data byte
    wire wdata_done = byte_done && (state_q == SSXC_WDATA);
    wire wr_ctrl = wdata_done && (ptr_q == SSXC_PTR_XFER_CTRL);
    wire mem_we = wdata_done && !wr_ctrl;
    // Read requests: after a read address byte and after each sent byte
    wire rdata_done = byte_done && (state_q == SSXC_RDATA);
    wire ab_rd_req = ab_done && ab_for_us && ab_read;
    wire mem_re = ab_rd_req || rdata_done;
    wire [4:0] mem_raddr = ab_rd_req ? ab_reg : next_ptr;
    wire [7:0] mem_rdata;
    wire [7:0] interface_status_byte = {drive_selected, dma_active, route_reserved, 2'h0,
                              transfer_route};

    ssxc_reg_store u_store (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wr_en(mem_we),
        .wr_addr(ptr_q),
        .wr_data(rx_byte),
        .rd_en(mem_re),
        .rd_addr(mem_raddr),
        .rd_data_q(mem_rdata)
    );

    // Link sequencing
    always_comb begin
        state_d = state_q;
        // RL8 sync pulse starts a command
        if (sync_rise) begin
            state_d = SSXC_ADDR;
        end else if (ab_done) begin
            // RL9 other device selected
            // RL15 direction from bit 0
            if (!ab_for_us) begin
                state_d = SSXC_IGNORE;
            end else if (ab_read) begin
                state_d = SSXC_RDATA;
            end else begin
                state_d = SSXC_WDATA;
            end
        end
    end

    // State, bit count and receive shift
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= SSXC_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
        end else begin
            state_q <= state_d;
            if (sync_rise) begin
                bit_cnt_q <= 3'h0;
            end else if (clk_rise) begin
                bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
                // RL18 sample on rising edge, MSB first
                shift_q <= rx_byte;
            end
        end
    end

    // Pointer and address mode
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ptr_q <= SSXC_PTR_PORT;
            mode_q <= 1'b0;
        end else if (ab_done && ab_for_us) begin
            // RL14 load pointer from address byte
            ptr_q <= ab_reg;
            mode_q <= rx_byte[SSXC_AB_MODE];
        end else if (wdata_done || rdata_done) begin
            // RL10 advance after each byte
            ptr_q <= next_ptr;
        end
    end

    // Transfer control register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            // RL16 reset value, drive one
            xc_q <= SSXC_XC_RESET;
        end else if (wr_ctrl) begin
            // RL19 reserved bit held low
            xc_q <= rx_byte & SSXC_XC_WMASK;
        end
    end

    // Transmit byte capture two cycles after each read request
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_load_q <= 1'b0;
            is_interface_status_q <= 1'b0;
            tx_byte_q <= 8'h00;
        end else begin
            tx_load_q <= mem_re;
            is_interface_status_q <= (mem_raddr == SSXC_PTR_INTERFACE_STATUS);
            if (tx_load_q) begin
                tx_byte_q <= is_interface_status_q ? interface_status_byte : mem_rdata;
            end
        end
    end

    // Data line drive; released outside a read of our own
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (state_d != SSXC_RDATA) begin
            // RL9 never drive when not addressed
            sda_oe <= 1'b0;
        end else if (clk_fall) begin
            // RL18 change after falling edge
            sda_oe <= ~tx_byte_q[3'(SSXC_LAST_BIT - bit_cnt_q)];
        end
    end

    // Route decode
    wire [2:0] route = xc_q[SSXC_XC_ROUTE_HI:0];
    // RL4 reserved 11x codes
    wire route_res_w = route[2] & route[1];
    // RL5 host to sub-CPU is PIO only
    wire pio_only_w = (route == SSXC_RT_HOST_SUB);
    wire host_mem_w = (route == SSXC_RT_MEM_HOST) || (route == SSXC_RT_HOST_MEM);
    wire fixed_w = pio_only_w || (route == SSXC_RT_SUB_HOST);
    // RL4 limit depends on host mode
    // RL5 twelve bytes, byte count ignored
    wire [15:0] max_w = host_mem_w ? (atapi_mode ? SSXC_MAX_ATAPI : SSXC_MAX_LEGACY) :
                        fixed_w ? SSXC_MAX_FIXED : SSXC_MAX_NONE;
    // RL2 DMA unless PIO-only or reserved route
    wire dma_w = xc_q[SSXC_XC_DMA] && !pio_only_w && !route_res_w;

    // Registered control outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            burst_style_sel <= 1'b0;
            dma_not_pio <= 1'b0;
            sub_irq_en <= 1'b0;
            own_drive_number <= 1'b1;
            transfer_route <= 3'h0;
            route_reserved <= 1'b0;
            route_pio_only <= 1'b0;
            route_max_bytes <= SSXC_MAX_NONE;
            dma_active <= 1'b0;
            drive_selected <= 1'b0;
            sub_transfer_irq <= 1'b0;
        end else begin
            // RL1 single or multi word burst
            burst_style_sel <= xc_q[SSXC_XC_BURST];
            dma_not_pio <= xc_q[SSXC_XC_DMA];
            sub_irq_en <= xc_q[SSXC_XC_IRQEN];
            own_drive_number <= xc_q[SSXC_XC_DRV];
            transfer_route <= route;
            route_reserved <= route_res_w;
            route_pio_only <= pio_only_w;
            route_max_bytes <= max_w;
            dma_active <= dma_w;
            // RL17 drive bits must match
            drive_selected <= (host_drive_select == xc_q[SSXC_XC_DRV]);
            // RL3 interrupt masked when disabled
            sub_transfer_irq <= sub_xfer_event & xc_q[SSXC_XC_IRQEN];
        end
    end
endmodule
`default_nettype wire

/* File: shared/ssxc_pkg.sv */
// Purpose: Constants for the sub-CPU serial port and transfer control
// Assumes: 5-bit register pointer, 8-bit registers
// Notes: Chain runs are given by first and last pointer values
package ssxc_pkg;
    // Link framing
    localparam int unsigned SSXC_BYTE_BITS = 8;
    localparam logic [2:0] SSXC_LAST_BIT = 3'h7;
    // Address byte fields
    localparam int unsigned SSXC_AB_SELECT = 7;
    localparam int unsigned SSXC_AB_MODE = 6;
    localparam int unsigned SSXC_AB_REG_HI = 5;
    localparam int unsigned SSXC_AB_REG_LO = 1;
    localparam int unsigned SSXC_AB_DIR = 0;
    // Register pointer values
    localparam logic [4:0] SSXC_PTR_PORT = 5'h00;
    localparam logic [4:0] SSXC_PTR_INTERFACE_STATUS = 5'h01;
    localparam logic [4:0] SSXC_PTR_XFER_CTRL = 5'h1c;
    localparam logic [4:0] SSXC_PTR_WRAP_LO = 5'h0f;
    localparam logic [4:0] SSXC_PTR_WRAP_HI = 5'h1f;
    // Read chain runs
    localparam logic [4:0] SSXC_RD_RUN1_FIRST = 5'h01;
    localparam logic [4:0] SSXC_RD_RUN1_LAST = 5'h11;
    localparam logic [4:0] SSXC_RD_RUN2_FIRST = 5'h12;
    localparam logic [4:0] SSXC_RD_RUN2_LAST = 5'h17;
    // Write chain runs, the first jumps to address 21
    localparam logic [4:0] SSXC_WR_RUN1_FIRST = 5'h01;
    localparam logic [4:0] SSXC_WR_RUN1_LAST = 5'h12;
    localparam logic [4:0] SSXC_WR_RUN2_FIRST = 5'h15;
    localparam logic [4:0] SSXC_WR_RUN2_LAST = 5'h1f;
    // Transfer control register fields and reset
    localparam int unsigned SSXC_XC_BURST = 6;
    localparam int unsigned SSXC_XC_DMA = 5;
    localparam int unsigned SSXC_XC_IRQEN = 4;
    localparam int unsigned SSXC_XC_DRV = 3;
    localparam int unsigned SSXC_XC_ROUTE_HI = 2;
    localparam logic [7:0] SSXC_XC_WMASK = 8'h7f;
    localparam logic [7:0] SSXC_XC_RESET = 8'h08;
    // Transfer routes
    localparam logic [2:0] SSXC_RT_MEM_HOST = 3'h0;
    localparam logic [2:0] SSXC_RT_HOST_MEM = 3'h1;
    localparam logic [2:0] SSXC_RT_HOST_SUB = 3'h4;
    localparam logic [2:0] SSXC_RT_SUB_HOST = 3'h5;
    // Byte limits per route
    localparam logic [15:0] SSXC_MAX_ATAPI = 16'hffff;
    localparam logic [15:0] SSXC_MAX_LEGACY = 16'h7fff;
    localparam logic [15:0] SSXC_MAX_FIXED = 16'h000c;
    localparam logic [15:0] SSXC_MAX_NONE = 16'h0000;
    // Link state machine
    typedef enum logic [2:0] {
        SSXC_IDLE = 3'b000,
        SSXC_ADDR = 3'b001,
        SSXC_WDATA = 3'b010,
        SSXC_RDATA = 3'b011,
        SSXC_IGNORE = 3'b100
    } ssxc_state_type;
endpackage

/* File: hw/ssxc_reg_store.sv */
// Purpose: Register storage behind the serial pointer
// Assumes: One write and one read port on sys_clk
// Notes: Read data come out of a register one cycle after the request
`timescale 1ns/10ps
`default_nettype none
module ssxc_reg_store (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Write port
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic rd_en,
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data_q
);
    logic [7:0] mem [32];

    // Storage, no reset needed
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read data
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

/* File: tb/ssxc_properties.sv */
// Purpose: Port assertions for the serial transfer control block
// Assumes: All outputs are registered on sys_clk
// Notes: Route checks wait for one settled cycle
`timescale 1ns/10ps
`default_nettype none
module ssxc_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Link and host pins
    input wire logic frame_sync,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic atapi_mode,
    input wire logic host_drive_select,
    input wire logic sub_xfer_event,
    // Control outputs
    input wire logic dma_not_pio,
    input wire logic sub_irq_en,
    input wire logic own_drive_number,
    input wire logic [2:0] transfer_route,
    input wire logic route_reserved,
    input wire logic route_pio_only,
    input wire logic [15:0] route_max_bytes,
    input wire logic dma_active,
    input wire logic drive_selected,
    input wire logic sub_transfer_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Decode inputs unchanged, so the registered outputs have caught up
    sequence s_settled;
        !$past(sys_rst) && $stable(transfer_route) && $stable(atapi_mode) && $stable(dma_not_pio);
    endsequence
    // Line let go within the pin filter delay
    sequence s_release;
        ##[1:8] !sda_oe;
    endsequence
    property p_open_drain;
        sda_out == 1'b0;
    endproperty
    property p_release;
        $rose(frame_sync) |-> s_release;
    endproperty
    // Event in one cycle, then the enable that was registered alongside it
    sequence s_irq_cause;
        sub_xfer_event ##1 sub_irq_en;
    endsequence
    // A control write can drop the enable while the event stands, so no wider window
    property p_irq_pass;
        s_irq_cause |-> sub_transfer_irq;
    endproperty
    property p_irq_mask;
        (!sub_irq_en || !$past(sub_xfer_event)) |-> !sub_transfer_irq;
    endproperty
    property p_drive;
        !$past(sys_rst) && $stable(host_drive_select) && $stable(own_drive_number)
            |-> drive_selected == (host_drive_select == own_drive_number);
    endproperty
    property p_host_sub;
        s_settled ##0 (transfer_route == 3'h4)
            |-> route_pio_only && !dma_active && route_max_bytes == 16'h000c;
    endproperty
    property p_sub_host;
        s_settled ##0 (transfer_route == 3'h5)
            |-> !route_pio_only && route_max_bytes == 16'h000c && dma_active == dma_not_pio;
    endproperty
    property p_long;
        s_settled ##0 (transfer_route[2:1] == 2'b00)
            |-> route_max_bytes == (atapi_mode ? 16'hffff : 16'h7fff) && dma_active == dma_not_pio;
    endproperty
    property p_reserved;
        s_settled ##0 (transfer_route[2:1] == 2'b11)
            |-> route_reserved && !dma_active && route_max_bytes == 16'h0000;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    a_release: assert property (p_release) else $error("data line held after sync");
    a_irq_pass: assert property (p_irq_pass) else $error("enabled irq not raised");
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
    a_drive: assert property (p_drive) else $error("drive select mismatch");
    a_host_sub: assert property (p_host_sub) else $error("route 4 decode wrong");
    a_sub_host: assert property (p_sub_host) else $error("route 5 decode wrong");
    a_long: assert property (p_long) else $error("memory route limit wrong");
    a_reserved: assert property (p_reserved) else $error("reserved route decode wrong");
endmodule
bind ssxc_top ssxc_properties u_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .frame_sync(frame_sync), .sda_out(sda_out),
    .sda_oe(sda_oe), .atapi_mode(atapi_mode), .host_drive_select(host_drive_select),
    .sub_xfer_event(sub_xfer_event), .dma_not_pio(dma_not_pio), .sub_irq_en(sub_irq_en),
    .own_drive_number(own_drive_number), .transfer_route(transfer_route),
    .route_reserved(route_reserved), .route_pio_only(route_pio_only),
    .route_max_bytes(route_max_bytes), .dma_active(dma_active),
    .drive_selected(drive_selected), .sub_transfer_irq(sub_transfer_irq)
);
`default_nettype wire

/* File: tb/ssxc_subcpu_model.sv */
// Purpose: Sub-CPU end of the three-wire register link
// Assumes: Pull-up on the data line, 200 ns bit clock
// Notes: Clock stands high between frames
`timescale 1ns/10ps
`default_nettype none
module ssxc_subcpu_model (
    // Link pins
    output logic frame_sync,
    output logic bit_clk,
    output logic sda_pull_low,
    // Resolved data line
    input wire logic sda_line
);
    initial begin
        frame_sync = 1'b0;
        bit_clk = 1'b1;
        sda_pull_low = 1'b0;
    end
    task automatic start_frame();
        frame_sync = 1'b1;
        #200;
        frame_sync = 1'b0;
        #200;
    endtask
    // MSB first, changed after the fall
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_clk = 1'b0;
            #20;
            sda_pull_low = !b[i];
            #80;
            bit_clk = 1'b1;
            #100;
        end
        sda_pull_low = 1'b0;
    endtask
    // sampled late while high, answer lags the fall
    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_clk = 1'b0;
            #100;
            bit_clk = 1'b1;
            #90;
            b[i] = sda_line;
            #10;
        end
    endtask
endmodule
`default_nettype wire

/* File: tb/test_subcpu_serial_xfer_control.sv */
// Purpose: Self-checking bench for the serial transfer control block
// Assumes: Sub-CPU model drives the link, bench drives host pins
// Notes: Registers never written hold unknowns and are skipped
`timescale 1ns/10ps
`default_nettype none
module test_subcpu_serial_xfer_control;
    import ssxc_pkg::*;
    logic sys_clk, sys_rst, atapi_mode, host_drive_select, sub_xfer_event, frame_sync, bit_clk;
    logic pull_low, sda_out, sda_oe, burst_style_sel, dma_not_pio, sub_irq_en, own_drive_number;
    logic route_reserved, route_pio_only, dma_active, drive_selected, sub_transfer_irq;
    logic [2:0] transfer_route;
    logic [15:0] route_max_bytes;
    logic [7:0] mem [32];
    logic [7:0] ctrl;
    int error_cnt = 0;
    int check_count = 0;
    wire logic sda_line;
    assign sda_line = !(sda_oe || pull_low);
    ssxc_top dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .frame_sync(frame_sync), .bit_clk(bit_clk),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .atapi_mode(atapi_mode),
        .host_drive_select(host_drive_select), .sub_xfer_event(sub_xfer_event),
        .burst_style_sel(burst_style_sel), .dma_not_pio(dma_not_pio), .sub_irq_en(sub_irq_en),
        .own_drive_number(own_drive_number), .transfer_route(transfer_route),
        .route_reserved(route_reserved), .route_pio_only(route_pio_only),
        .route_max_bytes(route_max_bytes), .dma_active(dma_active),
        .drive_selected(drive_selected), .sub_transfer_irq(sub_transfer_irq)
    );
    ssxc_subcpu_model sub (
        .frame_sync(frame_sync), .bit_clk(bit_clk), .sda_pull_low(pull_low), .sda_line(sda_line)
    );
    // 40 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [4:0] nxt(input logic mode, input logic rd, input logic [4:0] p);
        if (!mode) return (p == 0 || p == 15 || p == 31) ? 5'h00 : p + 5'h01;
        if (rd) return ((p >= 1 && p <= 16) || (p >= 18 && p <= 22)) ? p + 5'h01 : 5'h00;
        if (p == 18) return 5'h15;
        return ((p >= 1 && p <= 17) || (p >= 21 && p <= 30)) ? p + 5'h01 : 5'h00;
    endfunction
    function automatic logic [7:0] status();
        logic [2:0] r;
        r = ctrl[2:0];
        return {host_drive_select == ctrl[3], ctrl[5] && r != 3'h4 && r[2:1] != 2'b11,
            r[2:1] == 2'b11, 2'b00, r};
    endfunction
    // Write frame, random bytes unless v is given
    task automatic wr(input logic mode, input logic [4:0] p, input int n, input int v);
        logic [7:0] b;
        sub.start_frame();
        sub.put_byte({1'b0, mode, p, 1'b0});
        for (int i = 0; i < n; i++) begin
            b = (v < 0) ? 8'($urandom) : 8'(v);
            sub.put_byte(b);
            if (p == SSXC_PTR_XFER_CTRL) ctrl = b & 8'h7f;
            else mem[p] = b;
            p = nxt(mode, 1'b0, p);
        end
        #400;
    endtask
    task automatic rd(input logic sel, input logic mode, input logic [4:0] p, input int n);
        logic [7:0] b;
        logic [7:0] e;
        sub.start_frame();
        sub.put_byte({sel, mode, p, 1'b1});
        for (int i = 0; i < n; i++) begin
            sub.get_byte(b);
            e = sel ? 8'hff : (p == SSXC_PTR_INTERFACE_STATUS) ? status() : mem[p];
            if (^e !== 1'bx) chk("read byte", 16'(e), 16'(b));
            p = nxt(mode, 1'b1, p);
        end
    endtask
    task automatic check_outs();
        logic [15:0] m;
        m = (ctrl[2:1] == 2'b00) ? (atapi_mode ? 16'hffff : 16'h7fff) : 16'h0000;
        if (ctrl[2:1] == 2'b10) m = 16'h000c;
        @(negedge sys_clk);
        chk("burst", 16'(ctrl[6]), 16'(burst_style_sel));
        chk("dma", 16'(ctrl[5]), 16'(dma_not_pio));
        chk("irq_en", 16'(ctrl[4]), 16'(sub_irq_en));
        chk("drive", 16'(ctrl[3]), 16'(own_drive_number));
        chk("max", m, route_max_bytes);
        chk("pio", 16'(ctrl[2:0] == 3'h4), 16'(route_pio_only));
        chk("status", 16'(status()), 16'({drive_selected, dma_active, route_reserved,
            2'b00, transfer_route}));
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs about 0.25 ms
    initial begin
        #1_500_000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        void'($urandom(2373));
        sys_rst = 1'b1;
        atapi_mode = 1'b1;
        host_drive_select = 1'b1;
        sub_xfer_event = 1'b0;
        ctrl = SSXC_XC_RESET;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check_outs();
        wr(1'b0, 5'h01, 15, -1);
        wr(1'b0, 5'h10, 16, -1);
        wr(1'b0, 5'h0e, 5, -1);
        rd(1'b0, 1'b0, 5'h0d, 5);
        wr(1'b1, 5'h10, 5, -1);
        rd(1'b0, 1'b1, 5'h12, 7);
        rd(1'b0, 1'b1, 5'h02, 17);
        wr(1'b1, 5'h1e, 3, -1);
        rd(1'b0, 1'b0, 5'h1d, 4);
        // Command for another device must change nothing
        sub.start_frame();
        sub.put_byte(8'h84);
        sub.put_byte(~mem[2]);
        rd(1'b1, 1'b0, 5'h02, 2);
        rd(1'b0, 1'b0, 5'h02, 1);
        // legacy mode keeps to the four plain routes
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            atapi_mode <= (i >= 4);
            host_drive_select <= 1'($urandom);
            sub_xfer_event <= 1'($urandom);
            wr(1'b0, SSXC_PTR_XFER_CTRL, 1, int'({5'($urandom), 3'(i % 8)}));
            check_outs();
            chk("irq", 16'(sub_xfer_event & ctrl[4]), 16'(sub_transfer_irq));
            rd(1'b0, 1'b0, SSXC_PTR_INTERFACE_STATUS, 1);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
